// ==== logic/ras_pkg.sv ====
// Summary of operation
// - stack holds up to 31 nested return addresses from calls and interrupts
// - push pc on push, call, relative call and interrupt acknowledge
// - pop top entry into pc on pop, return, literal return, interrupt return
// - return instructions leave upper and high pc latches unchanged
// - storage is 31 entries of 21 bits behind a 5-bit pointer
// - entry bits 12 to 16 are not stored and read as zero
// - pointer clears on resetn_in reset and overflow reset, not on por_in alone; pointer zero has no entry
// - push increments pointer first, then writes pc at new pointer
// - pop copies selected entry to pc first, then decrements pointer
// - software reads and writes pointer and top-of-stack registers
// - full flag shows when pointer reached or exceeded 31 levels
// - top-of-stack registers always show entry selected by pointer
// - return after software rewrote top-of-stack loads rewritten value
// - pc bits 12 to 16 forced zero so high addresses mirror low 4k
// - small memory variant fetches zero words from 0x0800 to 0x0fff
// - reset vector 0000h, high interrupt 0008h, low interrupt 0018h
// - interrupt acknowledge pushes pc and loads high or low vector
// - overflow option set: 31st push stores, flags full, resets device
// - pop from empty stack returns zero, sets underflow, pointer stays zero
// - full and underflow flags clear only by software or power-on reset
package ras_pkg;
	localparam int unsigned PC_W = 21;
	localparam int unsigned SP_W = 5;
	localparam int unsigned DEPTH = 31;
	localparam logic [4:0] SP_MAX = 5'h1f;
	localparam logic [4:0] SP_LAST_FREE = 5'h1e;
	localparam logic [20:0] PC_HOLE_MASK = 21'h1e0fff;
	localparam logic [20:0] SMALL_LIMIT = 21'h000800;
	localparam logic [20:0] SMALL_TOP = 21'h000fff;
	localparam logic [20:0] RESET_VEC = 21'h000000;
	localparam logic [20:0] HIGH_VEC = 21'h000008;
	localparam logic [20:0] LOW_VEC = 21'h000018;
	localparam logic [3:0] A_TOS_LOW = 4'h0;
	localparam logic [3:0] A_TOS_HIGH = 4'h1;
	localparam logic [3:0] A_TOS_UPPER = 4'h2;
	localparam logic [3:0] A_SPTR = 4'h3;
	localparam logic [3:0] A_PC_LOW = 4'h4;
	localparam logic [3:0] A_PC_HIGH_LATCH = 4'h5;
	localparam logic [3:0] A_PC_UPPER_LATCH = 4'h6;
	localparam int unsigned FULL_BIT = 7;
	localparam int unsigned UNF_BIT = 6;
	localparam logic [7:0] REG_RESET = 8'h00;
	typedef enum logic [1:0] {RAS_NONE, RAS_PUSH, RAS_POP} ras_op_t;
endpackage

// ==== logic/ras_mem_if.sv ====
`timescale 1ns/1ps
interface ras_mem_if;
	logic we;
	logic [4:0] waddr;
	logic [20:0] wdata;
	logic [4:0] raddr;
	logic [20:0] rdata;
	modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ==== logic/ras_mem.sv ====
`timescale 1ns/1ps
module ras_mem (
	// clock
	input wire logic clock_in,
	// port
	ras_mem_if.mem m
);
	logic [20:0] ram_q [1:ras_pkg::DEPTH];
	always_ff @(posedge clock_in) begin
		if (m.we && m.waddr != 5'h00) begin
			ram_q[m.waddr] <= m.wdata & ras_pkg::PC_HOLE_MASK;
		end
	end
	// pointer zero reads zero
	assign m.rdata = (m.raddr == 5'h00) ? 21'h000000 : ram_q[m.raddr];
endmodule // ras_mem

// ==== logic/ras_top.sv ====
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module ras_top (
	// clock and reset
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire logic por_in,
	// configuration
	input wire logic overflow_reset_en_in,
	input wire logic small_mem_in,
	// sequencer
	input wire logic push_in,
	input wire logic pop_in,
	input wire logic irq_ack_in,
	input wire logic irq_high_in,
	input wire logic [20:0] pc_in,
	input wire logic [20:0] fetch_addr_in,
	input wire logic [15:0] fetch_word_in,
	// registers
	input wire logic [3:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	// results
	output logic pc_load_out,
	output logic [20:0] pc_value_out,
	output logic [20:0] fetch_addr_out,
	output logic [15:0] fetch_word_out,
	output logic [7:0] pc_high_latch_out,
	output logic [7:0] pc_upper_latch_out,
	output logic stack_reset_out
);
	logic [4:0] sp_q;
	logic full_q;
	logic unf_q;
	logic [7:0] pc_high_latch_q;
	logic [7:0] pc_upper_latch_q;
	logic [7:0] pc_low_q;
	logic [7:0] rdata_q;
	logic pc_load_q;
	logic [20:0] pc_value_q;
	logic [20:0] fetch_addr_q;
	logic [15:0] fetch_word_q;
	logic stk_rst_q;
	logic [4:0] sp_d;
	logic [20:0] tos;
	logic [20:0] tos_wr;
	logic tos_we;
	logic do_push;
	logic do_pop;
	logic sp_wr;
	ras_pkg::ras_op_t op;
	ras_mem_if mi ();

	function automatic logic [20:0] mirror(input logic [20:0] a);
		mirror = a & ras_pkg::PC_HOLE_MASK;
	endfunction

	function automatic logic reg_hit(input logic w, input logic [3:0] a, input logic [3:0] t);
		reg_hit = w && a == t;
	endfunction

	ras_mem i_ras_mem (
		.clock_in(clock_in),
		.m(mi.mem)
	);

	// call, push and interrupt acknowledge
	assign do_push = push_in | irq_ack_in;
	assign do_pop = pop_in & ~do_push;
	always_comb begin
		if (do_push) begin
			op = ras_pkg::RAS_PUSH;
		end else if (do_pop) begin
			op = ras_pkg::RAS_POP;
		end else begin
			op = ras_pkg::RAS_NONE;
		end
	end

	assign mi.raddr = sp_q;
	assign tos = mi.rdata;
	assign sp_wr = reg_hit(wr_in, addr_in, ras_pkg::A_SPTR) && op == ras_pkg::RAS_NONE;

	// top-of-stack byte write merges into selected entry
	always_comb begin
		tos_wr = tos;
		tos_we = 1'b0;
		if (wr_in && op == ras_pkg::RAS_NONE) begin
			unique case (addr_in)
				ras_pkg::A_TOS_LOW: begin
					tos_wr[7:0] = wdata_in;
					tos_we = 1'b1;
				end
				ras_pkg::A_TOS_HIGH: begin
					tos_wr[15:8] = wdata_in;
					tos_we = 1'b1;
				end
				ras_pkg::A_TOS_UPPER: begin
					tos_wr[20:16] = wdata_in[4:0];
					tos_we = 1'b1;
				end
				default: begin
					tos_we = 1'b0;
				end
			endcase
		end
	end

	// memory write: push goes to incremented pointer
	always_comb begin
		mi.we = 1'b0;
		mi.waddr = sp_q;
		mi.wdata = tos_wr;
		if (op == ras_pkg::RAS_PUSH && sp_q != ras_pkg::SP_MAX) begin
			mi.we = 1'b1;
			mi.waddr = sp_q + 5'h01;
			mi.wdata = pc_in;
		end else if (tos_we) begin
			mi.we = 1'b1;
		end
	end

	// pointer next value
	always_comb begin
		sp_d = sp_q;
		unique case (op)
			ras_pkg::RAS_PUSH: begin
				if (sp_q != ras_pkg::SP_MAX) begin
					sp_d = sp_q + 5'h01;
				end
				if (sp_q == ras_pkg::SP_LAST_FREE && overflow_reset_en_in) begin
					sp_d = 5'h00;
				end
			end
			ras_pkg::RAS_POP: begin
				if (sp_q != 5'h00) begin
					sp_d = sp_q - 5'h01;
				end
			end
			ras_pkg::RAS_NONE: begin
				if (sp_wr) begin
					sp_d = wdata_in[4:0];
				end
			end
		endcase
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sp_q <= 5'h00;
		end else begin
			sp_q <= sp_d;
		end
	end

	// sticky flags, set wins; other resets leave them alone
	always_ff @(posedge clock_in) begin
		if (por_in) begin
			full_q <= 1'b0;
			unf_q <= 1'b0;
		end else if (resetn_in) begin
			if (op == ras_pkg::RAS_PUSH && sp_q >= ras_pkg::SP_LAST_FREE) begin
				full_q <= 1'b1;
			end else if (sp_wr && !wdata_in[ras_pkg::FULL_BIT]) begin
				full_q <= 1'b0;
			end
			if (op == ras_pkg::RAS_POP && sp_q == 5'h00) begin
				unf_q <= 1'b1;
			end else if (sp_wr && !wdata_in[ras_pkg::UNF_BIT]) begin
				unf_q <= 1'b0;
			end
		end
	end

	// overflow reset request
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			stk_rst_q <= 1'b0;
		end else begin
			stk_rst_q <= op == ras_pkg::RAS_PUSH && sp_q == ras_pkg::SP_LAST_FREE &&
				overflow_reset_en_in;
		end
	end

	// pc load on pop or vector
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pc_load_q <= 1'b0;
			pc_value_q <= ras_pkg::RESET_VEC;
		end else begin
			pc_load_q <= 1'b0;
			if (irq_ack_in) begin
				pc_load_q <= 1'b1;
				pc_value_q <= irq_high_in ? ras_pkg::HIGH_VEC : ras_pkg::LOW_VEC;
			end else if (op == ras_pkg::RAS_POP) begin
				pc_load_q <= 1'b1;
				pc_value_q <= tos;
			end
		end
	end

	// program latches, not touched by returns
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pc_high_latch_q <= ras_pkg::REG_RESET;
			pc_upper_latch_q <= ras_pkg::REG_RESET;
			pc_low_q <= ras_pkg::REG_RESET;
		end else begin
			if (reg_hit(wr_in, addr_in, ras_pkg::A_PC_HIGH_LATCH)) begin
				pc_high_latch_q <= wdata_in;
			end
			if (reg_hit(wr_in, addr_in, ras_pkg::A_PC_UPPER_LATCH)) begin
				pc_upper_latch_q <= {3'h0, wdata_in[4:0]};
			end
			if (reg_hit(wr_in, addr_in, ras_pkg::A_PC_LOW)) begin
				pc_low_q <= {wdata_in[7:1], 1'b0};
			end
		end
	end

	// fetch mirroring and small variant blanking
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			fetch_addr_q <= 21'h000000;
			fetch_word_q <= 16'h0000;
		end else begin
			fetch_addr_q <= mirror(fetch_addr_in);
			if (small_mem_in && mirror(fetch_addr_in) >= ras_pkg::SMALL_LIMIT &&
				mirror(fetch_addr_in) <= ras_pkg::SMALL_TOP) begin
				fetch_word_q <= 16'h0000;
			end else begin
				fetch_word_q <= fetch_word_in;
			end
		end
	end

	// register read
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rdata_q <= 8'h00;
		end else if (rd_in) begin
			unique case (addr_in)
				ras_pkg::A_TOS_LOW: rdata_q <= tos[7:0];
				ras_pkg::A_TOS_HIGH: rdata_q <= tos[15:8];
				ras_pkg::A_TOS_UPPER: rdata_q <= {3'h0, tos[20:16]};
				ras_pkg::A_SPTR: rdata_q <= {full_q, unf_q, 1'b0, sp_q};
				ras_pkg::A_PC_LOW: rdata_q <= pc_low_q;
				ras_pkg::A_PC_HIGH_LATCH: rdata_q <= pc_high_latch_q;
				ras_pkg::A_PC_UPPER_LATCH: rdata_q <= pc_upper_latch_q;
				default: rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign rdata_out = rdata_q;
	assign pc_load_out = pc_load_q;
	assign pc_value_out = pc_value_q;
	assign fetch_addr_out = fetch_addr_q;
	assign fetch_word_out = fetch_word_q;
	assign pc_high_latch_out = pc_high_latch_q;
	assign pc_upper_latch_out = pc_upper_latch_q;
	assign stack_reset_out = stk_rst_q;

	a_push_incr: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(push_in && sp_q < 5'h1e) |=> sp_q == $past(sp_q) + 5'h01)
		else $error("push did not advance pointer");
	a_pop_decr: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(pop_in && !push_in && !irq_ack_in && sp_q != 5'h00) |=> sp_q == $past(sp_q) - 5'h01)
		else $error("pop did not drop pointer");
	a_pop_value: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(pop_in && !push_in && !irq_ack_in) |=> pc_load_out && pc_value_out == $past(tos))
		else $error("pop value wrong");
	a_unf_set: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(pop_in && !push_in && !irq_ack_in && sp_q == 5'h00 && !por_in) |=> unf_q && sp_q == 5'h00)
		else $error("underflow not flagged");
	a_full_set: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(push_in && sp_q == 5'h1e && !por_in) |=> full_q)
		else $error("full not flagged");
	a_ovf_hold: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(push_in && sp_q == 5'h1f) |=> sp_q == 5'h1f)
		else $error("pointer left top");
	a_vector_load: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(irq_ack_in && irq_high_in) |=> pc_value_out == 21'h000008)
		else $error("wrong high vector");
	a_mirror_addr: assert property (@(posedge clock_in) disable iff (!resetn_in)
		##1 fetch_addr_out[16:12] == 5'h00)
		else $error("mirror bits set");
	a_latch_keep: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(pop_in && !wr_in) |=> $stable(pc_high_latch_out) && $stable(pc_upper_latch_out))
		else $error("return moved latch");

	// pointer and software access
	a_swr_refused: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(push_in && wr_in && addr_in == ras_pkg::A_SPTR && sp_q < ras_pkg::SP_LAST_FREE)
		|=> sp_q == $past(sp_q) + 5'h01)
		else $error("pointer write beat push");
	a_sp_write: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(wr_in && addr_in == ras_pkg::A_SPTR && !push_in && !pop_in && !irq_ack_in)
		|=> sp_q == 5'($past(wdata_in)))
		else $error("pointer write lost");
	a_irq_push: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(irq_ack_in && sp_q < ras_pkg::SP_LAST_FREE) |=> sp_q == $past(sp_q) + 5'h01 &&
		tos == ($past(pc_in) & ras_pkg::PC_HOLE_MASK))
		else $error("interrupt did not push");
	a_lost_push: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(do_push && sp_q == ras_pkg::SP_MAX) |=> tos == $past(tos))
		else $error("push past top stored");
	a_rst_pulse: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(push_in && sp_q == ras_pkg::SP_LAST_FREE && overflow_reset_en_in && !por_in) |=>
		stack_reset_out && sp_q == 5'h00 && full_q)
		else $error("overflow reset missing");

	// top-of-stack contents and pc load
	a_empty_zero: assert property (@(posedge clock_in) disable iff (!resetn_in)
		sp_q == 5'h00 |-> tos == 21'h000000)
		else $error("empty entry not zero");
	a_hole_zero: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(do_push || tos_we) |=> tos[16:12] == 5'h00)
		else $error("unstored bits kept");
	a_tos_write: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(wr_in && addr_in == ras_pkg::A_TOS_LOW && !push_in && !pop_in && !irq_ack_in &&
		sp_q != 5'h00) |=> tos[7:0] == $past(wdata_in))
		else $error("top write lost");
	a_read_tos: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(rd_in && addr_in == ras_pkg::A_TOS_LOW) |=> rdata_out == 8'($past(tos)))
		else $error("top read wrong");
	a_load_idle: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(!do_pop && !irq_ack_in) |=> !pc_load_out)
		else $error("stray pc load");

	// flags
	a_full_keep: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(full_q && !por_in && !(sp_wr && !wdata_in[ras_pkg::FULL_BIT])) |=> full_q)
		else $error("full flag dropped");
	a_unf_keep: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(unf_q && !por_in && !(sp_wr && !wdata_in[ras_pkg::UNF_BIT])) |=> unf_q)
		else $error("underflow flag dropped");
	a_por_clear: assert property (@(posedge clock_in) disable iff (!resetn_in)
		por_in |=> !full_q && !unf_q)
		else $error("power-on left flags");

	// fetch blanking
	a_blank_fetch: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(small_mem_in && fetch_addr_in >= ras_pkg::SMALL_LIMIT &&
		fetch_addr_in <= ras_pkg::SMALL_TOP) |=> fetch_word_out == 16'h0000)
		else $error("blank range fetched data");
endmodule // ras_top

// ==== test/ras_seq_model.sv ====
`timescale 1ns/1ps
module ras_seq_model (
	// clock
	input wire logic clock_in,
	// sequencer requests
	output logic push_out,
	output logic pop_out,
	output logic irq_ack_out,
	output logic irq_high_out,
	output logic [20:0] pc_out
);
	initial begin
		push_out = 1'b0;
		pop_out = 1'b0;
		irq_ack_out = 1'b0;
		irq_high_out = 1'b0;
		pc_out = 21'h000000;
	end
	// one instruction cycle, irq never raised amid tos edits
	task automatic step(input logic p, input logic q, input logic i, input logic h,
		input logic [20:0] v);
		@(posedge clock_in);
		push_out <= p;
		pop_out <= q;
		irq_ack_out <= i;
		irq_high_out <= h;
		pc_out <= v;
		@(posedge clock_in);
		push_out <= 1'b0;
		pop_out <= 1'b0;
		irq_ack_out <= 1'b0;
		pc_out <= ~v;
	endtask
endmodule // ras_seq_model

// ==== test/return_address_stack_tb.sv ====
`timescale 1ns/1ps
module return_address_stack_tb;
	logic clock_in, resetn_in, por_in, ovr_en, small_mem, wr_in, rd_in;
	logic push_w, pop, irq_ack, irq_high, pc_load, stack_reset;
	logic [20:0] pc, fa, pc_value, fa_out;
	logic [15:0] fw, fw_out;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, hi_latch, up_latch;
	int fail_count = 0;
	int checks_done = 0;
	int resets_seen = 0;
	ras_seq_model i_ras_seq_model (.clock_in(clock_in), .push_out(push_w), .pop_out(pop),
		.irq_ack_out(irq_ack), .irq_high_out(irq_high), .pc_out(pc));
	ras_top i_ras_top (.clock_in(clock_in), .resetn_in(resetn_in), .por_in(por_in),
		.overflow_reset_en_in(ovr_en), .small_mem_in(small_mem), .push_in(push_w),
		.pop_in(pop), .irq_ack_in(irq_ack), .irq_high_in(irq_high), .pc_in(pc),
		.fetch_addr_in(fa), .fetch_word_in(fw), .addr_in(addr), .wdata_in(wdata),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata), .pc_load_out(pc_load),
		.pc_value_out(pc_value), .fetch_addr_out(fa_out), .fetch_word_out(fw_out),
		.pc_high_latch_out(hi_latch), .pc_upper_latch_out(up_latch),
		.stack_reset_out(stack_reset));
	initial begin
		clock_in = 1'b0;
		forever #2.5 clock_in = ~clock_in;
	end
	always @(posedge clock_in) if (stack_reset === 1'b1) resets_seen++;
	task automatic stop_test();
		$display("checks %0d errors %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: byte %h not %h", $time, got, exp);
		end
	endtask
	task automatic chk21(input logic [20:0] got, input logic [20:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: address %h not %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock_in);
		addr <= a;
		wdata <= d;
		wr_in <= 1'b1;
		@(posedge clock_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clock_in);
		addr <= a;
		rd_in <= 1'b1;
		@(posedge clock_in);
		rd_in <= 1'b0;
		#1 chk8(rdata, e);
	endtask
	task automatic push(input logic [20:0] v);
		i_ras_seq_model.step(1'b1, 1'b0, 1'b0, 1'b0, v);
	endtask
	// pop (i low) or interrupt acknowledge (i high), then the pc load result
	task automatic ld(input logic i, input logic h, input logic [20:0] e);
		i_ras_seq_model.step(1'b0, ~i, i, h, 21'h000456);
		#1 chk21(pc_value, e);
		chk21({20'h00000, pc_load}, 21'h000001);
	endtask
	task automatic fetch(input logic [20:0] a, input logic [20:0] ea, input logic [15:0] ew);
		@(posedge clock_in);
		fa <= a;
		fw <= 16'h1234;
		@(posedge clock_in);
		#1 chk21(fa_out, ea);
		chk21({5'h00, fw_out}, {5'h00, ew});
	endtask
	initial begin
		#100000;
		fail_count++;
		stop_test();
	end
	initial begin
		resetn_in = 1'b0;
		por_in = 1'b1;
		ovr_en = 1'b0;
		small_mem = 1'b0;
		wr_in = 1'b0;
		rd_in = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		fa = 21'h000000;
		fw = 16'h0000;
		repeat (4) @(posedge clock_in);
		resetn_in <= 1'b1;
		por_in <= 1'b0;
		wr(4'h7, 8'hff);
		for (int a = 0; a < 7; a++) begin
			rd(a[3:0], 8'h00);
		end
		push(21'h1fffff);
		rd(4'h3, 8'h01);
		rd(4'h0, 8'hff);
		rd(4'h1, 8'h0f);
		rd(4'h2, 8'h1e);
		push(21'h012345);
		ld(1'b0, 1'b0, 21'h000345);
		ld(1'b0, 1'b0, 21'h1e0fff);
		rd(4'h3, 8'h00);
		ld(1'b0, 1'b0, 21'h000000);
		rd(4'h3, 8'h40);
		push(21'h000000);
		rd(4'h3, 8'h41);
		@(posedge clock_in);
		resetn_in <= 1'b0;
		repeat (2) @(posedge clock_in);
		resetn_in <= 1'b1;
		rd(4'h3, 8'h40);
		@(posedge clock_in);
		por_in <= 1'b1;
		@(posedge clock_in);
		por_in <= 1'b0;
		rd(4'h3, 8'h00);
		push(21'h000000);
		wr(4'h0, 8'h34);
		wr(4'h1, 8'h02);
		wr(4'h2, 8'h03);
		wr(4'h5, 8'h5a);
		wr(4'h6, 8'h05);
		rd(4'h2, 8'h02);
		ld(1'b0, 1'b0, 21'h020234);
		chk8(hi_latch, 8'h5a);
		chk8(up_latch, 8'h05);
		wr(4'h3, 8'h03);
		rd(4'h3, 8'h03);
		fork
			wr(4'h3, 8'h10);
			push(21'h000077);
		join
		rd(4'h3, 8'h04);
		wr(4'h3, 8'h00);
		for (int h = 0; h < 2; h++) begin
			ld(1'b1, h[0], h[0] ? 21'h000008 : 21'h000018);
			rd(4'h3, 8'h01 + h[7:0]);
			rd(4'h0, 8'h56);
		end
		wr(4'h3, 8'h00);
		for (int i = 1; i < 33; i++) begin
			push(21'(i));
		end
		rd(4'h3, 8'h9f);
		rd(4'h0, 8'h1f);
		wr(4'h3, 8'h00);
		rd(4'h3, 8'h00);
		@(posedge clock_in);
		ovr_en <= 1'b1;
		for (int i = 1; i < 32; i++) begin
			push(21'(i));
		end
		repeat (2) @(posedge clock_in);
		chk8(8'(resets_seen), 8'h01);
		rd(4'h3, 8'h80);
		fetch(21'h001234, 21'h000234, 16'h1234);
		@(posedge clock_in);
		small_mem <= 1'b1;
		fetch(21'h000900, 21'h000900, 16'h0000);
		fetch(21'h0007fe, 21'h0007fe, 16'h1234);
		stop_test();
	end
endmodule // return_address_stack_tb
